// *** rtl/xma_core.sv ***
/*
 * xma_core: far memory alu datapath with its own data memory, run
 * by commands written over axi4-lite.
 * assumes one clock, a synchronous active-low reset and a master that
 * keeps at most one write and one read under way.
 */
// The AXI4-Lite interface to the registers and the placing of the registers were left to the implementer.
// Function
// [RULE1] memory operand addressed by flat full address, no bank select used
// [RULE2] store-from-accumulator copies accumulator to memory, flags kept
// [RULE3] bitwise union of accumulator and memory, to acc or memory, zero only
// [RULE4] plain rotate up of memory byte, top bit wraps to bit zero, no flags
// [RULE5] rotate up through carry: old carry to bit zero, top bit to carry
// [RULE6] plain rotate down, bit zero wraps to top bit, flags untouched
// [RULE7] rotate down through carry: old carry to top, bit zero to carry
// [RULE8] accumulator rotate forms write accumulator only, memory kept
// [RULE9] minus with borrow: acc minus memory minus inverted carry
// [RULE10] subtraction carry clear on negative, set on zero or positive
// [RULE11] subtractions update fault, zero, nibble carry, carry, sign, chain
// [RULE12] plain minus: acc minus memory, to acc or memory
// [RULE13] decrement skip writes memory minus one, skips on zero, no flags
// [RULE14] accumulator decrement skip loads acc only, skips when acc zero
// [RULE15] increment skip writes memory plus one, skips on zero
// [RULE16] accumulator increment skip loads acc only, skips when acc zero
// [RULE17] skipping operation takes three cycles with a dummy cycle
// [RULE18] bit skip skips when selected bit is one
// [RULE19] byte skip rewrites same byte, skips when it is non-zero
// [RULE20] fill ones loads all ones into memory byte, flags kept
// [RULE21] set bit forces selected bit only, flags kept
// [RULE22] zero flag set when eight-bit result is zero, else cleared
`timescale 1ns/1ps
`default_nettype none

module xma_core
    import xma_pkg::*;
(
    input wire logic aclk,             // core clock
    input wire logic aresetn,          // sync reset, low
    input wire logic [7:0] s_awaddr,   // write address
    input wire logic s_awvalid,        // write address valid
    output logic s_awready,            // write address ready
    input wire logic [31:0] s_wdata,   // write data
    input wire logic [3:0] s_wstrb,    // byte enables
    input wire logic s_wvalid,         // write data valid
    output logic s_wready,             // write data ready
    output logic [1:0] s_bresp,        // write response
    output logic s_bvalid,             // write response valid
    input wire logic s_bready,         // write response ready
    input wire logic [7:0] s_araddr,   // read address
    input wire logic s_arvalid,        // read address valid
    output logic s_arready,            // read address ready
    output logic [31:0] s_rdata,       // read data
    output logic [1:0] s_rresp,        // read response
    output logic s_rvalid,             // read data valid
    input wire logic s_rready,         // read data ready
    output logic busy,                 // command in progress
    output logic skip_next,            // last command skipped
    output logic op_done               // one-cycle end pulse
);

    // =========================================================
    // storage
    // =========================================================
    xma_state_s_t s;
    xma_state_s_t next_s;

    // flat array: every section is reachable by the full address
    logic [7:0] mem [XMA_DEPTH];

    logic mem_we;
    logic [XMA_AW-1:0] mem_wa;
    logic [7:0] mem_wd;

    // byte-lane merge for partial writes
    function automatic logic [31:0] xma_merge(
        input logic [31:0] old,
        input logic [31:0] nw,
        input logic [3:0] strb
    );
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                r[i*8 +: 8] = nw[i*8 +: 8];
            end
        end
        return r;
    endfunction

    // =========================================================
    // handshakes and outputs
    // =========================================================
    // each write channel takes one item and waits for the pair
    assign s_awready = !s.aw_held;
    assign s_wready = !s.w_held;
    assign s_arready = !s.rvalid;
    assign s_bvalid = s.bvalid;
    assign s_bresp = s.bresp;
    assign s_rvalid = s.rvalid;
    assign s_rdata = s.rdata;
    assign s_rresp = s.rresp;
    assign busy = (s.st != ST_IDLE);
    assign skip_next = s.skip;
    assign op_done = s.done;

    // =========================================================
    // next state
    // =========================================================
    logic [31:0] wr;
    logic commit;
    logic [7:0] m;
    logic [7:0] a;
    logic cin;
    logic bw;
    logic [8:0] diff;
    logic [4:0] nib;
    logic [7:0] res;
    logic [7:0] bmask;
    logic [31:0] rd;

    always_comb begin
        next_s = s;
        next_s.done = 1'b0;
        mem_we = 1'b0;
        mem_wa = s.addr;
        mem_wd = 8'h00;
        m = s.opnd;
        a = s.acc;
        cin = s.flags[XMA_F_C];
        bw = 1'b0;
        diff = 9'h000;
        nib = 5'h00;
        res = 8'h00;
        bmask = 8'h01 << s.bsel;
        rd = 32'h0000_0000;
        wr = xma_merge(32'h0000_0000, s.wdata, s.wstrb);
        commit = s.aw_held && s.w_held && !s.bvalid;

        // take address and data in either order
        if (s_awvalid && s_awready) begin
            next_s.aw_held = 1'b1;
            next_s.aw_addr = s_awaddr;
        end
        if (s_wvalid && s_wready) begin
            next_s.w_held = 1'b1;
            next_s.wdata = s_wdata;
            next_s.wstrb = s_wstrb;
        end

        // write commit; while busy the block owns acc, flags, memory
        if (commit) begin
            next_s.aw_held = 1'b0;
            next_s.w_held = 1'b0;
            next_s.bvalid = 1'b1;
            next_s.bresp = XMA_OKAY;
            case ({s.aw_addr[7:2], 2'b00})
                XMA_CMD: begin
                    if (s.st == ST_IDLE) begin
                        next_s.op = wr[XMA_CMD_OP_LSB +: 5];
                        next_s.bsel = wr[XMA_CMD_BIT_LSB +: 3];
                        next_s.addr = wr[XMA_CMD_ADR_LSB +: XMA_AW]; // [RULE1]
                        next_s.skip = 1'b0;
                        next_s.st = ST_FETCH;
                    end
                end
                XMA_ACC: begin
                    if (s.st == ST_IDLE && s.wstrb[0]) begin
                        next_s.acc = s.wdata[7:0];
                    end
                end
                XMA_FLAGS: begin
                    if (s.st == ST_IDLE && s.wstrb[0]) begin
                        next_s.flags = s.wdata[5:0];
                    end
                end
                XMA_STATUS: begin
                    next_s.bresp = XMA_OKAY; // read only, write dropped
                end
                XMA_WIN_ADDR: begin
                    wr = xma_merge({22'h0, s.win}, s.wdata, s.wstrb);
                    next_s.win = wr[XMA_AW-1:0];
                end
                XMA_WIN_DATA: begin
                    if (s.st == ST_IDLE && s.wstrb[0]) begin
                        mem_we = 1'b1;
                        mem_wa = s.win;
                        mem_wd = s.wdata[7:0];
                    end
                end
                default: begin
                    next_s.bresp = XMA_SLVERR;
                end
            endcase
        end
        if (s.bvalid && s_bready) begin
            next_s.bvalid = 1'b0;
        end

        // read path, data held until taken
        case ({s_araddr[7:2], 2'b00})
            XMA_CMD: rd = {14'h0, s.addr, s.bsel, s.op};
            XMA_ACC: rd = {24'h0, s.acc};
            XMA_FLAGS: rd = {26'h0, s.flags};
            XMA_STATUS: rd = {30'h0, s.skip, (s.st != ST_IDLE)};
            XMA_WIN_ADDR: rd = {22'h0, s.win};
            XMA_WIN_DATA: rd = {24'h0, mem[s.win]};
            default: rd = 32'h0000_0000;
        endcase
        if (s_arvalid && s_arready) begin
            next_s.rvalid = 1'b1;
            next_s.rdata = rd;
            case ({s_araddr[7:2], 2'b00})
                XMA_CMD, XMA_ACC, XMA_FLAGS, XMA_STATUS,
                XMA_WIN_ADDR, XMA_WIN_DATA: next_s.rresp = XMA_OKAY;
                default: next_s.rresp = XMA_SLVERR;
            endcase
        end
        if (s.rvalid && s_rready) begin
            next_s.rvalid = 1'b0;
        end

        // sequencer: fetch operand, execute, optional dummy slot
        case (s.st)
            ST_IDLE: begin
            end
            ST_FETCH: begin
                next_s.opnd = mem[s.addr]; // [RULE1]
                next_s.st = ST_EXEC;
            end
            ST_EXEC: begin
                next_s.st = ST_IDLE;
                next_s.done = 1'b1;
                // borrow in only for the with-borrow forms
                if (s.op == OP_FAR_MINUS_WITH_BORROW ||
                    s.op == OP_FAR_MINUS_WITH_BORROW_TO_MEM) begin
                    bw = !cin; // [RULE9]
                end
                diff = {1'b0, a} - {1'b0, m} - {8'h00, bw};
                nib = {1'b0, a[3:0]} - {1'b0, m[3:0]} - {4'h0, bw};
                case (s.op)
                    OP_FAR_STORE_FROM_ACCUMULATOR: begin
                        mem_we = 1'b1;
                        mem_wd = a; // [RULE2]
                    end
                    OP_FAR_BITWISE_UNION_TO_ACC,
                    OP_FAR_BITWISE_UNION_TO_MEM: begin
                        res = a | m; // [RULE3]
                        next_s.flags[XMA_F_Z] = (res == 8'h00); // [RULE22]
                        if (s.op == OP_FAR_BITWISE_UNION_TO_MEM) begin
                            mem_we = 1'b1;
                            mem_wd = res;
                        end else begin
                            next_s.acc = res;
                        end
                    end
                    OP_FAR_ROTATE_UP: begin
                        mem_we = 1'b1;
                        mem_wd = {m[6:0], m[7]}; // [RULE4]
                    end
                    OP_FAR_ROTATE_UP_TO_ACC: begin
                        next_s.acc = {m[6:0], m[7]}; // [RULE4] [RULE8]
                    end
                    OP_FAR_ROTATE_UP_THRU_CARRY: begin
                        mem_we = 1'b1;
                        mem_wd = {m[6:0], cin}; // [RULE5]
                        next_s.flags[XMA_F_C] = m[7];
                    end
                    OP_FAR_ROTATE_UP_THRU_CARRY_TO_ACC: begin
                        next_s.acc = {m[6:0], cin}; // [RULE5] [RULE8]
                        next_s.flags[XMA_F_C] = m[7];
                    end
                    OP_FAR_ROTATE_DOWN: begin
                        mem_we = 1'b1;
                        mem_wd = {m[0], m[7:1]}; // [RULE6]
                    end
                    OP_FAR_ROTATE_DOWN_TO_ACC: begin
                        next_s.acc = {m[0], m[7:1]}; // [RULE6] [RULE8]
                    end
                    OP_FAR_ROTATE_DOWN_THRU_CARRY: begin
                        mem_we = 1'b1;
                        mem_wd = {cin, m[7:1]}; // [RULE7]
                        next_s.flags[XMA_F_C] = m[0];
                    end
                    OP_FAR_ROTATE_DOWN_THRU_CARRY_TO_ACC: begin
                        next_s.acc = {cin, m[7:1]}; // [RULE7] [RULE8]
                        next_s.flags[XMA_F_C] = m[0];
                    end
                    OP_FAR_MINUS_WITH_BORROW,
                    OP_FAR_MINUS_WITH_BORROW_TO_MEM,
                    OP_FAR_MINUS,
                    OP_FAR_MINUS_TO_MEM: begin
                        res = diff[7:0]; // [RULE9] [RULE12]
                        // carry reads as an active-low borrow
                        next_s.flags[XMA_F_C] = !diff[8]; // [RULE10]
                        next_s.flags[XMA_F_NIB] = !nib[4]; // [RULE11]
                        next_s.flags[XMA_F_Z] = (res == 8'h00); // [RULE22]
                        next_s.flags[XMA_F_RANGE] = (a[7] != m[7]) &&
                            (res[7] != a[7]); // [RULE11]
                        next_s.flags[XMA_F_SIGN] = ((a[7] != m[7]) &&
                            (res[7] != a[7])) ^ res[7]; // [RULE11]
                        // chained zero keeps multi-byte zero across borrows
                        if (s.op == OP_FAR_MINUS || s.op == OP_FAR_MINUS_TO_MEM) begin
                            next_s.flags[XMA_F_CHAIN] = (res == 8'h00); // [RULE11]
                        end else begin
                            next_s.flags[XMA_F_CHAIN] = (res == 8'h00) &&
                                s.flags[XMA_F_CHAIN]; // [RULE11]
                        end
                        if (s.op == OP_FAR_MINUS_WITH_BORROW_TO_MEM ||
                            s.op == OP_FAR_MINUS_TO_MEM) begin
                            mem_we = 1'b1;
                            mem_wd = res;
                        end else begin
                            next_s.acc = res;
                        end
                    end
                    OP_FAR_DECREMENT_SKIP_ZERO: begin
                        res = m - 8'h01;
                        mem_we = 1'b1;
                        mem_wd = res; // [RULE13]
                        next_s.skip = (res == 8'h00);
                    end
                    OP_FAR_DECREMENT_SKIP_ZERO_TO_ACC: begin
                        res = m - 8'h01;
                        next_s.acc = res; // [RULE14]
                        next_s.skip = (res == 8'h00);
                    end
                    OP_FAR_INCREMENT_SKIP_ZERO: begin
                        res = m + 8'h01;
                        mem_we = 1'b1;
                        mem_wd = res; // [RULE15]
                        next_s.skip = (res == 8'h00);
                    end
                    OP_FAR_INCREMENT_SKIP_ZERO_TO_ACC: begin
                        res = m + 8'h01;
                        next_s.acc = res; // [RULE16]
                        next_s.skip = (res == 8'h00);
                    end
                    OP_FAR_SKIP_NONZERO_BIT: begin
                        next_s.skip = |(m & bmask); // [RULE18]
                    end
                    OP_FAR_SKIP_NONZERO: begin
                        mem_we = 1'b1;
                        mem_wd = m; // [RULE19]
                        next_s.skip = (m != 8'h00);
                    end
                    OP_FAR_FILL_ONES: begin
                        mem_we = 1'b1;
                        mem_wd = XMA_ONES; // [RULE20]
                    end
                    OP_FAR_SET_BIT: begin
                        mem_we = 1'b1;
                        mem_wd = m | bmask; // [RULE21]
                    end
                    default: begin
                    end
                endcase
                // a taken skip spends one more cycle on the dummy slot
                if (next_s.skip) begin
                    next_s.st = ST_DUMMY; // [RULE17]
                    next_s.done = 1'b0;
                end
            end
            ST_DUMMY: begin
                next_s.st = ST_IDLE; // [RULE17]
                next_s.done = 1'b1;
            end
            default: begin
                next_s.st = ST_IDLE;
            end
        endcase
    end

    // =========================================================
    // registers
    // =========================================================
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s <= '0;
            s.st <= ST_IDLE;
            s.acc <= XMA_ACC_RST;
            s.flags <= XMA_FLAGS_RST;
            s.bresp <= XMA_OKAY;
            s.rresp <= XMA_OKAY;
        end else begin
            s <= next_s;
        end
    end

    // memory has no reset; contents are software's concern
    always_ff @(posedge aclk) begin
        if (mem_we) begin
            mem[mem_wa] <= mem_wd;
        end
    end

endmodule // xma_core

`default_nettype wire

// *** rtl/xma_pkg.sv ***
/*
 * xma_pkg: constants, register map, opcodes and state for the far
 * memory alu datapath.
 * assumes a 32-bit axi4-lite master and one 40 MHz clock.
 */
package xma_pkg;

    // =========================================================
    // widths and memory
    // =========================================================
    localparam int XMA_AW = 10;             // flat byte address
    localparam int XMA_DEPTH = 1024;        // data memory bytes

    // =========================================================
    // register byte offsets
    // =========================================================
    localparam logic [7:0] XMA_CMD = 8'h00;
    localparam logic [7:0] XMA_ACC = 8'h04;
    localparam logic [7:0] XMA_FLAGS = 8'h08;
    localparam logic [7:0] XMA_STATUS = 8'h0C;
    localparam logic [7:0] XMA_WIN_ADDR = 8'h10;
    localparam logic [7:0] XMA_WIN_DATA = 8'h14;

    // command field positions
    localparam int XMA_CMD_OP_LSB = 0;      // 5 bits
    localparam int XMA_CMD_BIT_LSB = 5;     // 3 bits
    localparam int XMA_CMD_ADR_LSB = 8;     // 10 bits

    // flag positions in the flags register
    localparam int XMA_F_C = 0;
    localparam int XMA_F_NIB = 1;
    localparam int XMA_F_Z = 2;
    localparam int XMA_F_RANGE = 3;
    localparam int XMA_F_SIGN = 4;
    localparam int XMA_F_CHAIN = 5;

    // status bit positions
    localparam int XMA_S_BUSY = 0;
    localparam int XMA_S_SKIP = 1;

    // reset values and fixed patterns
    localparam logic [7:0] XMA_ACC_RST = 8'h00;
    localparam logic [5:0] XMA_FLAGS_RST = 6'h00;
    localparam logic [7:0] XMA_ONES = 8'hFF;
    localparam logic [1:0] XMA_OKAY = 2'h0;
    localparam logic [1:0] XMA_SLVERR = 2'h2;

    // =========================================================
    // opcodes
    // =========================================================
    typedef enum logic [4:0] {
        OP_FAR_STORE_FROM_ACCUMULATOR = 5'h00,
        OP_FAR_BITWISE_UNION_TO_ACC = 5'h01,
        OP_FAR_BITWISE_UNION_TO_MEM = 5'h02,
        OP_FAR_ROTATE_UP = 5'h03,
        OP_FAR_ROTATE_UP_TO_ACC = 5'h04,
        OP_FAR_ROTATE_UP_THRU_CARRY = 5'h05,
        OP_FAR_ROTATE_UP_THRU_CARRY_TO_ACC = 5'h06,
        OP_FAR_ROTATE_DOWN = 5'h07,
        OP_FAR_ROTATE_DOWN_TO_ACC = 5'h08,
        OP_FAR_ROTATE_DOWN_THRU_CARRY = 5'h09,
        OP_FAR_ROTATE_DOWN_THRU_CARRY_TO_ACC = 5'h0A,
        OP_FAR_MINUS_WITH_BORROW = 5'h0B,
        OP_FAR_MINUS_WITH_BORROW_TO_MEM = 5'h0C,
        OP_FAR_DECREMENT_SKIP_ZERO = 5'h0D,
        OP_FAR_DECREMENT_SKIP_ZERO_TO_ACC = 5'h0E,
        OP_FAR_FILL_ONES = 5'h0F,
        OP_FAR_SET_BIT = 5'h10,
        OP_FAR_INCREMENT_SKIP_ZERO = 5'h11,
        OP_FAR_INCREMENT_SKIP_ZERO_TO_ACC = 5'h12,
        OP_FAR_SKIP_NONZERO_BIT = 5'h13,
        OP_FAR_SKIP_NONZERO = 5'h14,
        OP_FAR_MINUS = 5'h15,
        OP_FAR_MINUS_TO_MEM = 5'h16
    } xma_op_t;

    // one-hot sequencer states
    typedef enum logic [3:0] {
        ST_IDLE = 4'h1,
        ST_FETCH = 4'h2,
        ST_EXEC = 4'h4,
        ST_DUMMY = 4'h8
    } xma_state_t;

    // whole module state except the data memory
    typedef struct packed {
        xma_state_t st;
        logic [4:0] op;
        logic [2:0] bsel;
        logic [XMA_AW-1:0] addr;
        logic [7:0] opnd;
        logic [7:0] acc;
        logic [5:0] flags;
        logic skip;
        logic done;
        logic [XMA_AW-1:0] win;
        logic aw_held;
        logic [7:0] aw_addr;
        logic w_held;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
    } xma_state_s_t;

endpackage

// *** tb/xma_core_props.sv ***
/* xma_core_props: timing checks on command sequencing and bus answers.
   assumes the ports of xma_core, bound from the bench top file. */
`timescale 1ns/1ps
`default_nettype none

module xma_core_props (
    input wire logic aclk,       // core clock
    input wire logic aresetn,    // sync reset, low
    input wire logic s_bvalid,   // write response valid
    input wire logic s_bready,   // write response ready
    input wire logic s_arvalid,  // read address valid
    input wire logic s_arready,  // read address ready
    input wire logic s_rvalid,   // read data valid
    input wire logic s_rready,   // read data ready
    input wire logic busy,       // command running
    input wire logic skip_next,  // last command skipped
    input wire logic op_done     // end pulse
);
    // =========================================================
    // command timing
    // =========================================================
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    a_done_single: assert property (op_done |=> !op_done)
        else $error("done pulse longer than one cycle");
    a_skip_three: assert property (op_done && skip_next |->
        $past(busy, 1) && $past(busy, 2) && $past(busy, 3))
        else $error("skipping command not three cycles");
    a_plain_two: assert property (op_done && !skip_next |->
        $past(busy, 1) && $past(busy, 2) && !$past(busy, 3))
        else $error("plain command not two cycles");
    a_busy_bound: assert property ($rose(busy) |-> ##[2:3] op_done)
        else $error("command did not finish in time");
    a_skip_steady: assert property ($changed(skip_next) |-> op_done || busy)
        else $error("skip flag moved while idle");

    // =========================================================
    // bus answers
    // =========================================================
    // one read at a time, so the answer must fall right after its handshake
    a_read_answer: assert property (s_arvalid && s_arready |=> s_rvalid)
        else $error("read answer late");
    a_read_once: assert property (s_rvalid && s_rready |=> !s_rvalid)
        else $error("read answer repeated");
    a_write_once: assert property (s_bvalid && s_bready |=> !s_bvalid)
        else $error("write answer repeated");
    a_read_block: assert property (s_rvalid |-> !s_arready)
        else $error("read address taken while answer pending");
endmodule // xma_core_props

`default_nettype wire

// *** tb/extended_memory_alu_ops_tb.sv ***
/* extended_memory_alu_ops_tb: runs every opcode over axi4-lite and checks
   accumulator, memory byte, flags and skip. assumes xma_core and xma_pkg. */
`timescale 1ns/1ps
`default_nettype none

module extended_memory_alu_ops_tb
    import xma_pkg::*;
;
    logic aclk = 1'b0, aresetn = 1'b0;
    logic [7:0] s_awaddr = 8'h00, s_araddr = 8'h00;
    logic [31:0] s_wdata = 32'h0, s_rdata;
    logic [3:0] s_wstrb = 4'hF;
    logic s_awvalid = 1'b0, s_wvalid = 1'b0, s_bready = 1'b0;
    logic s_arvalid = 1'b0, s_rready = 1'b0;
    logic s_awready, s_wready, s_bvalid, s_arready, s_rvalid, busy, skip_next, op_done;
    logic [1:0] s_bresp, s_rresp, last_resp;
    logic [31:0] r;
    int bad_count = 0, tests_run = 0, cyc = 0;

    xma_core DUT (.aclk, .aresetn, .s_awaddr, .s_awvalid, .s_awready, .s_wdata, .s_wstrb,
        .s_wvalid, .s_wready, .s_bresp, .s_bvalid, .s_bready, .s_araddr, .s_arvalid,
        .s_arready, .s_rdata, .s_rresp, .s_rvalid, .s_rready, .busy, .skip_next, .op_done);

    initial begin
        forever #12.5 aclk = ~aclk;
    end

    // =========================================================
    // bus tasks, ready and answer taken at the rising edge
    // =========================================================
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic tb;
        s_awaddr <= a;
        s_wdata <= d;
        s_awvalid <= 1'b1;
        s_wvalid <= 1'b1;
        s_bready <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_awready && s_awvalid) s_awvalid <= 1'b0;
            if (s_wready && s_wvalid) s_wvalid <= 1'b0;
            tb = s_bvalid;
            last_resp = s_bresp;
        end while (!tb);
        s_bready <= 1'b0;
        @(posedge aclk);
    endtask

    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        logic got;
        s_araddr <= a;
        s_arvalid <= 1'b1;
        s_rready <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_arready && s_arvalid) s_arvalid <= 1'b0;
            got = s_rvalid;
            d = s_rdata;
            last_resp = s_rresp;
        end while (!got);
        s_rready <= 1'b0;
        @(posedge aclk);
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            bad_count++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // load operands, launch one command at a far address, check all results
    task automatic run(input logic [4:0] op, input logic [2:0] b, input logic [7:0] m, a, f,
            ea, em, ef, input logic es);
        logic [31:0] s;
        wr(XMA_WIN_ADDR, 32'h3A5);
        wr(XMA_WIN_DATA, {24'h0, m});
        wr(XMA_ACC, {24'h0, a});
        wr(XMA_FLAGS, {24'h0, f});
        wr(XMA_CMD, {14'h0, 10'h3A5, b, op});
        do rd(XMA_STATUS, s);
        while (s[XMA_S_BUSY] !== 1'b0);
        chk(s, {30'h0, es, 1'b0});
        rd(XMA_ACC, s);
        chk(s, {24'h0, ea});
        rd(XMA_WIN_DATA, s);
        chk(s, {24'h0, em});
        rd(XMA_FLAGS, s);
        chk(s, {24'h0, ef});
    endtask

    task automatic report_and_stop;
        $display("comparisons %0d mismatches %0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    // hang guard, far above the thousand or so cycles the sequence needs
    always @(posedge aclk) begin
        cyc++;
        if (cyc > 8000) begin
            bad_count++;
            report_and_stop;
        end
    end

    // =========================================================
    // main sequence
    // =========================================================
    initial begin
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        rd(XMA_ACC, r);
        chk(r, {24'h0, XMA_ACC_RST});
        rd(8'h3C, r);
        chk(r, 32'h0);
        chk({30'h0, last_resp}, {30'h0, XMA_SLVERR});
        wr(8'h3C, 32'h0);
        chk({30'h0, last_resp}, {30'h0, XMA_SLVERR});
        run(5'h00,3'h0,8'h11,8'h5A,8'h3F,8'h5A,8'h5A,8'h3F,1'b0);
        run(5'h01,3'h0,8'h00,8'h00,8'h00,8'h00,8'h00,8'h04,1'b0);
        run(5'h02,3'h0,8'h30,8'h0F,8'h3F,8'h0F,8'h3F,8'h3B,1'b0);
        run(5'h03,3'h0,8'h81,8'h00,8'h3F,8'h00,8'h03,8'h3F,1'b0);
        run(5'h04,3'h0,8'h81,8'h00,8'h00,8'h03,8'h81,8'h00,1'b0);
        run(5'h05,3'h0,8'h80,8'h00,8'h00,8'h00,8'h00,8'h01,1'b0);
        run(5'h06,3'h0,8'h01,8'h00,8'h01,8'h03,8'h01,8'h00,1'b0);
        run(5'h07,3'h0,8'h01,8'h00,8'h3F,8'h00,8'h80,8'h3F,1'b0);
        run(5'h08,3'h0,8'h02,8'h00,8'h00,8'h01,8'h02,8'h00,1'b0);
        run(5'h09,3'h0,8'h01,8'h00,8'h00,8'h00,8'h00,8'h01,1'b0);
        run(5'h0A,3'h0,8'h02,8'h00,8'h01,8'h81,8'h02,8'h00,1'b0);
        run(5'h15,3'h0,8'h05,8'h05,8'h00,8'h00,8'h05,8'h27,1'b0);
        run(5'h16,3'h0,8'h01,8'h00,8'h00,8'h00,8'hFF,8'h10,1'b0);
        run(5'h0B,3'h0,8'h01,8'h80,8'h00,8'h7E,8'h01,8'h19,1'b0);
        run(5'h0C,3'h0,8'h10,8'h10,8'h01,8'h10,8'h00,8'h07,1'b0);
        run(5'h0D,3'h0,8'h01,8'h00,8'h3F,8'h00,8'h00,8'h3F,1'b1);
        run(5'h0D,3'h0,8'h02,8'h00,8'h00,8'h00,8'h01,8'h00,1'b0);
        run(5'h0E,3'h0,8'h01,8'h77,8'h00,8'h00,8'h01,8'h00,1'b1);
        run(5'h11,3'h0,8'hFF,8'h00,8'h00,8'h00,8'h00,8'h00,1'b1);
        run(5'h12,3'h0,8'hFE,8'h00,8'h00,8'hFF,8'hFE,8'h00,1'b0);
        run(5'h13,3'h7,8'h80,8'h00,8'h00,8'h00,8'h80,8'h00,1'b1);
        run(5'h13,3'h0,8'hFE,8'h00,8'h00,8'h00,8'hFE,8'h00,1'b0);
        run(5'h14,3'h0,8'h00,8'h00,8'h00,8'h00,8'h00,8'h00,1'b0);
        run(5'h14,3'h0,8'h40,8'h00,8'h00,8'h00,8'h40,8'h00,1'b1);
        run(5'h0F,3'h0,8'h12,8'h00,8'h00,8'h00,8'hFF,8'h00,1'b0);
        run(5'h10,3'h3,8'h00,8'h00,8'h3F,8'h00,8'h08,8'h3F,1'b0);
        report_and_stop;
    end
endmodule // extended_memory_alu_ops_tb

bind xma_core xma_core_props u_props (.aclk, .aresetn, .s_bvalid, .s_bready, .s_arvalid,
    .s_arready, .s_rvalid, .s_rready, .busy, .skip_next, .op_done);

`default_nettype wire
